// ===== design/pstr_defs.svh
// register map, field positions, reset values and timing codes of the
// trigger router; assumes it is included by bare name from pstr files
`ifndef PSTR_DEFS_SVH
`define PSTR_DEFS_SVH

// byte offsets on the register bus
`define PSTR_OFF_MODE 12'h000
`define PSTR_OFF_TIMING 12'h004
`define PSTR_OFF_ROUTE 12'h008
`define PSTR_OFF_STATUS 12'h00C

// trigger_output_mode fields
`define PSTR_MODE_PROT_EN_BIT 0
`define PSTR_MODE_VAR_ROUTE_BIT 1
`define PSTR_MODE_RESET 32'h0000_0000

// timing select fields, one nibble per channel, low three bits used
`define PSTR_TSEL_LSB(ch) ((ch) * 4)
`define PSTR_TSEL_W 3
`define PSTR_TIMING_RESET 32'h0000_0000

// route select field
`define PSTR_ROUTE_LSB 0
`define PSTR_ROUTE_RESET 32'h0000_0000

// status fields
`define PSTR_STAT_LAST_LSB 0
`define PSTR_STAT_PROT_BIT 8

// timing codes
`define PSTR_T_OFF0 3'h0
`define PSTR_T_DOWN 3'h1
`define PSTR_T_UP 3'h2
`define PSTR_T_BOTH 3'h3
`define PSTR_T_PEAK 3'h4
`define PSTR_T_BOTTOM 3'h5
`define PSTR_T_PK_BOT 3'h6
`define PSTR_T_OFF7 3'h7

// route codes above this value select no line
`define PSTR_ROUTE_LAST 3'h5

`endif

// ===== design/pstr_pkg.sv
// types shared by the trigger router files
// assumes pstr_defs.svh sits beside it
package pstr_pkg;

  // timing select field of one channel
  typedef logic [2:0] pstr_tsel_t;

  // carrier events from the pwm counter, all on pclk
  typedef struct packed {
    logic count_up;
    logic peak;
    logic bottom;
    logic edge_aligned;
    logic triangular;
  } pstr_carrier_t;

  // apb request as seen by the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pstr_apb_req_t;

endpackage : pstr_pkg

// ===== design/pstr_event_qual.sv
// one trigger channel: picks the counter event that its timing select names
// assumes match and carrier events come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "pstr_defs.svh"

module pstr_event_qual
  import pstr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire pstr_tsel_t tsel,
  input wire logic match,
  input wire logic cmp_is_one,
  input wire pstr_carrier_t carrier,
  output logic fire
);

  ////////////////////////////////////////////////////////////////////////
  logic cond;
  logic cond_q;
  logic cond_d;
  pstr_tsel_t eff;
  logic up_m;
  logic down_m;

  // edge-aligned carriers never count down nor reach a bottom
  always_comb
  begin
    eff = tsel;
    if (carrier.edge_aligned)
    begin
      if (tsel == `PSTR_T_DOWN) eff = `PSTR_T_UP;
      if (tsel == `PSTR_T_BOTTOM) eff = `PSTR_T_PEAK;
      if (tsel == `PSTR_T_PK_BOT) eff = `PSTR_T_PEAK;
      if (tsel == `PSTR_T_BOTH) eff = `PSTR_T_UP;
    end
  end

  assign up_m = match & carrier.count_up;
  assign down_m = match & ~carrier.count_up;

  // decode of the timing code
  always_comb
  begin
    case (eff)
      `PSTR_T_DOWN: cond = down_m;
      `PSTR_T_UP: cond = up_m;
      // a compare of one on a triangle hits down then up around the
      // bottom; keeping only the up side gives one trigger per period
      `PSTR_T_BOTH: cond = (cmp_is_one && carrier.triangular) ?
                           up_m : match;
      `PSTR_T_PEAK: cond = carrier.peak;
      `PSTR_T_BOTTOM: cond = carrier.bottom;
      `PSTR_T_PK_BOT: cond = carrier.peak | carrier.bottom;
      default: cond = 1'b0;
    endcase
  end

  // only the first cycle of a held event counts
  assign cond_d = cond;
  assign fire = cond & ~cond_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cond_q <= 1'b0;
    else
      cond_q <= cond_d;
  end

endmodule : pstr_event_qual
`default_nettype wire

// ===== design/pstr_trigger_router.sv
// trigger router: apb registers, four timing qualifiers and the routing of
// their events onto six converter start lines
// assumes the pwm counter, compare logic, protection logic and sector
// logic all run on pclk and deliver one-cycle event pulses or levels
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pstr_defs.svh"

// Overview of operation
// - codes: 0/7 off, 1 down, 2 up, 3 either, 4 peak, 5 bottom, 6 both.
// - peak/bottom setting fires at every carrier peak and, unless edge-aligned, every bottom.
// - edge-aligned: down-match acts as up-match, bottom as peak.
// - either match, compare one, triangle: one trigger per period.
// - fixed routing: compares 0..3 drive lines 0..3, lines 4,5 low.
// - variable routing: only compare 0 fires, to selected or sector line.
// - in protection state, triggers stop unless the enable bit is set.
// - route codes 0..5 pick lines 0..5; codes 6 and 7 give nothing.
module pstr_trigger_router
  import pstr_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int NUM_LINES = 6
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pstr_carrier_t carrier,
  input wire logic [NUM_CH-1:0] cmp_match,
  input wire logic [NUM_CH-1:0] cmp_is_one,
  input wire logic emergency_protection,
  input wire logic ve_route_en,
  input wire logic [2:0] ve_sector,
  output logic adc_start_line_0,
  output logic adc_start_line_1,
  output logic adc_start_line_2,
  output logic adc_start_line_3,
  output logic adc_start_line_4,
  output logic adc_start_line_5
);

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic prot_en_q;
  logic prot_en_d;
  logic var_route_q;
  logic var_route_d;
  pstr_tsel_t tsel_q [NUM_CH];
  pstr_tsel_t tsel_d [NUM_CH];
  logic [2:0] route_q;
  logic [2:0] route_d;
  logic [NUM_LINES-1:0] last_q;
  logic [NUM_LINES-1:0] last_d;
  logic [NUM_LINES-1:0] lines_q;
  logic [NUM_LINES-1:0] lines_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;

  pstr_apb_req_t req;
  logic access;
  logic wr;
  logic rd;
  logic hit;

  ////////////////////////////////////////////////////////////////////////
  // apb decode; the slave never waits, so pready stays high
  assign req = '{sel: psel, enable: penable, write: pwrite,
                 addr: paddr, wdata: pwdata};
  assign access = req.sel & ~req.enable;
  // a write lands only at the access edge, where pready is sampled high
  assign wr = req.sel & req.enable & req.write & pready;
  assign rd = access & ~req.write;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // known offsets only; anything else answers with an error
  always_comb
  begin
    case (req.addr)
      `PSTR_OFF_MODE,
      `PSTR_OFF_TIMING,
      `PSTR_OFF_ROUTE,
      `PSTR_OFF_STATUS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // register writes at the access edge; read data is caught at the setup
  // edge instead, so it stands from a flip-flop for the whole access
  always_comb
  begin
    prot_en_d = prot_en_q;
    var_route_d = var_route_q;
    route_d = route_q;
    for (int i = 0; i < NUM_CH; i++)
      tsel_d[i] = tsel_q[i];
    if (wr && req.addr == `PSTR_OFF_MODE)
    begin
      prot_en_d = req.wdata[`PSTR_MODE_PROT_EN_BIT];
      var_route_d = req.wdata[`PSTR_MODE_VAR_ROUTE_BIT];
    end
    if (wr && req.addr == `PSTR_OFF_TIMING)
    begin
      for (int i = 0; i < NUM_CH; i++)
        tsel_d[i] = req.wdata[`PSTR_TSEL_LSB(i) +: `PSTR_TSEL_W];
    end
    if (wr && req.addr == `PSTR_OFF_ROUTE)
      route_d = req.wdata[`PSTR_ROUTE_LSB +: 3];
  end

  // read data, reserved bits read as zero
  always_comb
  begin
    prdata_d = 32'h0000_0000;
    pslverr_d = 1'b0;
    if (access)
    begin
      pslverr_d = ~hit;
      if (rd)
      begin
        case (req.addr)
          `PSTR_OFF_MODE:
          begin
            prdata_d[`PSTR_MODE_PROT_EN_BIT] = prot_en_q;
            prdata_d[`PSTR_MODE_VAR_ROUTE_BIT] = var_route_q;
          end
          `PSTR_OFF_TIMING:
          begin
            for (int i = 0; i < NUM_CH; i++)
              prdata_d[`PSTR_TSEL_LSB(i) +: `PSTR_TSEL_W] = tsel_q[i];
          end
          `PSTR_OFF_ROUTE: prdata_d[`PSTR_ROUTE_LSB +: 3] = route_q;
          `PSTR_OFF_STATUS:
          begin
            prdata_d[`PSTR_STAT_LAST_LSB +: NUM_LINES] = last_q;
            prdata_d[`PSTR_STAT_PROT_BIT] = emergency_protection;
          end
          default: prdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-channel event selection
  logic [NUM_CH-1:0] fire;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      pstr_event_qual u_qual (
        .pclk(pclk),
        .presetn(presetn),
        .tsel(tsel_q[g]),
        .match(cmp_match[g]),
        .cmp_is_one(cmp_is_one[g]),
        .carrier(carrier),
        .fire(fire[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // routing onto the start lines
  logic [2:0] dest;
  logic allow;

  // sector information from the vector engine overrides the route field
  assign dest = ve_route_en ? ve_sector : route_q;

  // protection gate sits after routing so every line is covered alike
  assign allow = ~emergency_protection | prot_en_q;

  always_comb
  begin
    lines_d = '0;
    if (!var_route_q)
    begin
      lines_d[NUM_CH-1:0] = fire;
    end
    else if (fire[0] && dest <= `PSTR_ROUTE_LAST)
    begin
      // compares 1 to 3 are ignored in this mode
      lines_d[dest] = 1'b1;
    end
    if (!allow)
      lines_d = '0;
  end

  // keep the last non-empty pattern for software to inspect
  assign last_d = (lines_d != '0) ? lines_d : last_q;

  assign adc_start_line_0 = lines_q[0];
  assign adc_start_line_1 = lines_q[1];
  assign adc_start_line_2 = lines_q[2];
  assign adc_start_line_3 = lines_q[3];
  assign adc_start_line_4 = lines_q[4];
  assign adc_start_line_5 = lines_q[5];

  ////////////////////////////////////////////////////////////////////////
  // state registers, all cleared by reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prot_en_q <= 1'(`PSTR_MODE_RESET >> `PSTR_MODE_PROT_EN_BIT);
      var_route_q <= 1'(`PSTR_MODE_RESET >> `PSTR_MODE_VAR_ROUTE_BIT);
      route_q <= 3'(`PSTR_ROUTE_RESET >> `PSTR_ROUTE_LSB);
      for (int i = 0; i < NUM_CH; i++)
        tsel_q[i] <= pstr_tsel_t'(`PSTR_TIMING_RESET >> `PSTR_TSEL_LSB(i));
      last_q <= '0;
      lines_q <= '0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prot_en_q <= prot_en_d;
      var_route_q <= var_route_d;
      route_q <= route_d;
      for (int i = 0; i < NUM_CH; i++)
        tsel_q[i] <= tsel_d[i];
      last_q <= last_d;
      lines_q <= lines_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

endmodule : pstr_trigger_router
`default_nettype wire

// ===== verif/pstr_props.sv
// port checker for the trigger router
// assumes it is bound onto pstr_trigger_router
`timescale 1ns/1ps
`default_nettype none
module pstr_props
  import pstr_pkg::*;
#(
  parameter int NUM_CH = 4
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire pstr_carrier_t carrier,
  input wire logic [NUM_CH-1:0] cmp_match,
  input wire logic adc_start_line_0,
  input wire logic adc_start_line_1,
  input wire logic adc_start_line_2,
  input wire logic adc_start_line_3,
  input wire logic adc_start_line_4,
  input wire logic adc_start_line_5
);
  wire logic [5:0] ln;
  // lines gathered so one compare covers all six
  assign ln = {adc_start_line_5, adc_start_line_4, adc_start_line_3,
    adc_start_line_2, adc_start_line_1, adc_start_line_0};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  // no counter event at all in a cycle
  sequence s_quiet;
    !(|cmp_match) && !carrier.peak && !carrier.bottom;
  endsequence
  // edge-aligned carrier at bottom with nothing else going on
  sequence s_bottom_ea;
    carrier.edge_aligned && carrier.bottom && !carrier.peak && !(|cmp_match);
  endsequence
  a_ready_always: assert property (pready)
    else $error("pready low");
  a_err_access: assert property (pslverr |-> psel && penable && prdata == 0)
    else $error("pslverr outside access or with data");
  a_rdata_access: assert property (prdata != 32'h0 |-> psel && penable)
    else $error("prdata left standing");
  a_quiet_lines: assert property (s_quiet |=> ln == 6'h00)
    else $error("line pulse without event");
  a_ea_no_bottom: assert property (s_bottom_ea |=> ln == 6'h00)
    else $error("bottom fired in edge-aligned mode");
  a_pulse_single: assert property (ln != 6'h00 |=>
    (ln & $past(ln)) == 0)
    else $error("line high two cycles");
  a_high_lines_cause: assert property (ln[5:4] != 2'h0 |->
    $past(cmp_match[0] | carrier.peak | carrier.bottom))
    else $error("line 4 or 5 without compare 0");
  a_line1_cause: assert property (ln[1] |->
    $past(cmp_match[1] | cmp_match[0] | carrier.peak | carrier.bottom))
    else $error("line 1 without cause");
endmodule : pstr_props
bind pstr_trigger_router pstr_props #(.NUM_CH(NUM_CH)) i_pstr_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .carrier(carrier),
  .cmp_match(cmp_match), .adc_start_line_0(adc_start_line_0),
  .adc_start_line_1(adc_start_line_1), .adc_start_line_2(adc_start_line_2),
  .adc_start_line_3(adc_start_line_3), .adc_start_line_4(adc_start_line_4),
  .adc_start_line_5(adc_start_line_5));
`default_nettype wire

// ===== verif/pstr_adc_model.sv
// converter start model: counts start requests on the six lines
// assumes single-cycle pulses on pclk
`timescale 1ns/1ps
`default_nettype none
module pstr_adc_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [5:0] start,
  output var int starts
);
  // every high cycle is one conversion start, so a stretched pulse shows
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      starts <= 0;
    else
      starts <= starts + $countones(start);
endmodule : pstr_adc_model
`default_nettype wire

// ===== verif/test_pwm_sync_trigger_router.sv
// self-checking bench for the trigger router
// assumes pstr_props is bound and pstr_adc_model is compiled beside it
`timescale 1ns/1ps
`default_nettype none
`include "pstr_defs.svh"
module test_pwm_sync_trigger_router
  import pstr_pkg::*;
;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, pready, pslverr, emergency_protection = 1'h0;
  logic ve_route_en = 1'h0;
  logic [2:0] ve_sector = 3'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] cmp_match = 4'h0, cmp_is_one = 4'h0;
  pstr_carrier_t carrier = 5'h00;
  wire logic [5:0] ln;
  int starts, num_errors = 0, n_tests = 0, cyc = 0, exp_starts = 0;
  logic [4:0] evc [4] = '{5'h00, 5'h10, 5'h08, 5'h04};
  pstr_trigger_router i_pstr_trigger_router (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .carrier(carrier), .cmp_match(cmp_match), .cmp_is_one(cmp_is_one),
    .emergency_protection(emergency_protection), .ve_route_en(ve_route_en),
    .ve_sector(ve_sector), .adc_start_line_0(ln[0]),
    .adc_start_line_1(ln[1]), .adc_start_line_2(ln[2]),
    .adc_start_line_3(ln[3]), .adc_start_line_4(ln[4]),
    .adc_start_line_5(ln[5]));
  pstr_adc_model i_pstr_adc_model (.pclk(pclk), .presetn(presetn),
    .start(ln), .starts(starts));
  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial forever #50 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // one apb transfer; waits an edge first so psel is never set twice at once
  task automatic apb(input logic wr, logic [11:0] a, logic [31:0] d,
    logic [31:0] e, logic err);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    // the wait ends as soon as pready is sampled high
    while (pready !== 1'h1)
      @(posedge pclk);
    if (!wr)
      chk("prdata", e, prdata);
    chk("pslverr", err, pslverr);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // event in one cycle, pulse expected in the next, quiet in the one after
  task automatic pulse(input logic [3:0] m, logic [4:0] car, logic [5:0] e);
    @(posedge pclk);
    cmp_match <= m;
    carrier <= car;
    @(posedge pclk);
    cmp_match <= 4'h0;
    carrier <= car & 5'h13;
    #1 chk("lines", e, ln);
    @(posedge pclk);
    #1 chk("lines after", 6'h00, ln);
    exp_starts += $countones(e);
  endtask : pulse
  // ev: 0 down match, 1 up match, 2 peak, 3 bottom
  function automatic logic fires(input logic [2:0] c, int ev, logic ea);
    logic [3:0] hit;
    case (c)
      3'h1: hit = ea ? 4'h2 : 4'h1;
      3'h2: hit = 4'h2;
      3'h3: hit = ea ? 4'h2 : 4'h3;
      3'h4: hit = 4'h4;
      3'h5: hit = ea ? 4'h4 : 4'h8;
      3'h6: hit = ea ? 4'h4 : 4'hC;
      default: hit = 4'h0;
    endcase
    return hit[ev];
  endfunction : fires
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, `PSTR_OFF_MODE, 32'h0, `PSTR_MODE_RESET, 1'h0);
    apb(1'h0, `PSTR_OFF_TIMING, 32'h0, `PSTR_TIMING_RESET, 1'h0);
    apb(1'h0, `PSTR_OFF_ROUTE, 32'h0, `PSTR_ROUTE_RESET, 1'h0);
    apb(1'h0, 12'h010, 32'h0, 32'h0, 1'h1);
    apb(1'h1, `PSTR_OFF_TIMING, 32'hFFFF_FFFF, 32'h0, 1'h0);
    apb(1'h0, `PSTR_OFF_TIMING, 32'h0, 32'h0000_7777, 1'h0);
    $display("test registers done");
    for (int ea = 0; ea < 2; ea++)
      for (int c = 0; c < 8; c++)
      begin
        apb(1'h1, `PSTR_OFF_TIMING, c, 32'h0, 1'h0);
        for (int ev = 0; ev < 4; ev++)
          pulse(ev < 2 ? 4'h1 : 4'h0, evc[ev] | (ea ? 5'h02 : 5'h01),
            {5'h00, fires(c[2:0], ev, ea[0])});
      end
    $display("test timing codes done");
    apb(1'h1, `PSTR_OFF_TIMING, 32'h3, 32'h0, 1'h0);
    cmp_is_one <= 4'h1;
    pulse(4'h1, 5'h01, 6'h00);
    pulse(4'h1, 5'h11, 6'h01);
    cmp_is_one <= 4'h0;
    $display("test compare one done");
    apb(1'h1, `PSTR_OFF_TIMING, 32'h2222, 32'h0, 1'h0);
    pulse(4'hF, 5'h10, 6'h0F);
    pulse(4'hA, 5'h10, 6'h0A);
    $display("test fixed routing done");
    apb(1'h1, `PSTR_OFF_MODE, 32'h2, 32'h0, 1'h0);
    for (int r = 0; r < 8; r++)
    begin
      apb(1'h1, `PSTR_OFF_ROUTE, r, 32'h0, 1'h0);
      pulse(4'hF, 5'h10, r < 6 ? 6'h01 << r : 6'h00);
    end
    ve_route_en <= 1'h1;
    ve_sector <= 3'h4;
    pulse(4'hE, 5'h10, 6'h00);
    pulse(4'h1, 5'h10, 6'h10);
    ve_route_en <= 1'h0;
    $display("test variable routing done");
    emergency_protection <= 1'h1;
    apb(1'h1, `PSTR_OFF_MODE, 32'h0, 32'h0, 1'h0);
    pulse(4'h1, 5'h10, 6'h00);
    apb(1'h1, `PSTR_OFF_MODE, 32'h1, 32'h0, 1'h0);
    pulse(4'h1, 5'h10, 6'h01);
    apb(1'h0, `PSTR_OFF_STATUS, 32'h0, 32'h0000_0101, 1'h0);
    emergency_protection <= 1'h0;
    $display("test protection done");
    chk("starts", exp_starts, starts);
    // reset in mid-run must clear what software wrote
    presetn <= 1'h0;
    @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, `PSTR_OFF_MODE, 32'h0, `PSTR_MODE_RESET, 1'h0);
    apb(1'h0, `PSTR_OFF_ROUTE, 32'h0, `PSTR_ROUTE_RESET, 1'h0);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule : test_pwm_sync_trigger_router
`default_nettype wire
